// >>> logic/dtc_pkg.sv
// Constants, types and field layout of the debug trace and compare registers
package dtc_pkg;

  // ***********************************************************
  // Register addresses, byte registers
  // ***********************************************************
  localparam logic [3:0] ADDR_CMP_A_HIGH    = 4'h0;
  localparam logic [3:0] ADDR_CMP_A_LOW     = 4'h1;
  localparam logic [3:0] ADDR_CMP_B_HIGH    = 4'h2;
  localparam logic [3:0] ADDR_CMP_B_LOW     = 4'h3;
  localparam logic [3:0] ADDR_FIFO_HIGH     = 4'h4;
  localparam logic [3:0] ADDR_FIFO_LOW      = 4'h5;
  localparam logic [3:0] ADDR_CONTROL       = 4'h6;
  localparam logic [3:0] ADDR_FORCED_RESET  = 4'h7;

  // ***********************************************************
  // Field positions and reset values
  // ***********************************************************
  localparam int         BIT_FORCE_RESET    = 0;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [15:0] RESET_WORD        = 16'h0000;
  localparam logic [3:0] RESET_COUNT        = 4'h0;
  localparam int         FIFO_DEPTH         = 8;
  localparam int         FIFO_LAST          = FIFO_DEPTH - 1;
  localparam logic [3:0] FIFO_FULL_COUNT    = 4'h8;

  // ***********************************************************
  // Trigger modes
  // ***********************************************************
  localparam logic [3:0] TRG_A_ONLY         = 4'h0;
  localparam logic [3:0] TRG_A_OR_B         = 4'h1;
  localparam logic [3:0] TRG_A_THEN_B       = 4'h2;
  localparam logic [3:0] TRG_EVENT_B        = 4'h3;
  localparam logic [3:0] TRG_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] TRG_A_AND_B_DATA   = 4'h5;
  localparam logic [3:0] TRG_A_NOT_B_DATA   = 4'h6;
  localparam logic [3:0] TRG_INSIDE         = 4'h7;
  localparam logic [3:0] TRG_OUTSIDE        = 4'h8;

  // ***********************************************************
  // Types
  // ***********************************************************
  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic module_enable;
    logic arm;
    logic trigger_type_select;
    logic break_request_enable;
    logic cmp_a_direction;
    logic cmp_a_direction_qualify;
    logic cmp_b_direction;
    logic cmp_b_direction_qualify;
  } dtc_ctrl_s;

  localparam dtc_ctrl_s RESET_CTRL = 8'h00;

  // CPU bus cycle seen by the comparators
  typedef struct packed {
    logic        valid;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  data;
  } dtc_bus_s;

  typedef enum logic [1:0] {
    DTC_IDLE = 2'b00,
    DTC_WAIT = 2'b01,
    DTC_FILL = 2'b11
  } dtc_state_e;

endpackage : dtc_pkg

// >>> logic/dtc_trace.sv
// Debug comparators, trace FIFO, control and forced-reset registers
module dtc_trace (
  // Clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             RESET,
  // Register port in the ordinary memory map
  input  wire logic [3:0]       REG_ADDR,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [7:0]       REG_WDATA,
  output logic      [7:0]       REG_RDATA,
  // Serial background command write port
  input  wire logic [3:0]       BDC_ADDR,
  input  wire logic             BDC_WR,
  input  wire logic [7:0]       BDC_WDATA,
  // CPU observation
  input  wire dtc_pkg::dtc_bus_s CPU_BUS,
  input  wire logic             COF_VALID,
  input  wire logic [15:0]      COF_ADDR,
  input  wire logic [15:0]      LAST_OPCODE_ADDR,
  input  wire logic             MCU_SECURE,
  // Trigger setup held outside this block
  input  wire logic [3:0]       TRIGGER_MODE,
  input  wire logic             BEGIN_TRACE,
  // Status and requests
  output logic                  RUN_ACTIVE_FLAG,
  output logic      [3:0]       FIFO_VALID_COUNT,
  output logic                  MATCH_A_FLAG,
  output logic                  MATCH_B_FLAG,
  output logic                  BREAK_FORCE,
  output logic                  BREAK_TAG,
  output logic                  SYSTEM_RESET_REQ
);

  // ***********************************************************
  // State
  // ***********************************************************
  logic [15:0]          cmp_a;
  logic [15:0]          cmp_b;
  dtc_pkg::dtc_ctrl_s   ctrl;
  dtc_pkg::dtc_state_e  state;
  logic [15:0]          fifo [dtc_pkg::FIFO_DEPTH];
  logic [3:0]           count;
  logic                 seen_a;
  logic                 flag_a;
  logic                 flag_b;
  logic [7:0]           rdata;
  logic                 brk_force;
  logic                 brk_tag;
  logic                 sys_reset;

  logic [15:0]          next_cmp_a;
  logic [15:0]          next_cmp_b;
  dtc_pkg::dtc_ctrl_s   next_ctrl;
  dtc_pkg::dtc_state_e  next_state;
  logic [15:0]          next_fifo [dtc_pkg::FIFO_DEPTH];
  logic [3:0]           next_count;
  logic                 next_seen_a;
  logic                 next_flag_a;
  logic                 next_flag_b;
  logic [7:0]           next_rdata;
  logic                 next_brk_force;
  logic                 next_brk_tag;
  logic                 next_sys_reset;

  // ***********************************************************
  // Comparators and trigger
  // ***********************************************************
  logic        match_a;
  logic        match_b;
  logic        data_b;
  logic        in_range;
  logic        trig;
  logic        event_only;
  logic        begin_mode;

  always_comb begin
    match_a = CPU_BUS.valid && (CPU_BUS.addr == cmp_a) &&
              (!ctrl.cmp_a_direction_qualify ||
               (CPU_BUS.read == ctrl.cmp_a_direction));
    match_b = CPU_BUS.valid && (CPU_BUS.addr == cmp_b) &&
              (!ctrl.cmp_b_direction_qualify ||
               (CPU_BUS.read == ctrl.cmp_b_direction));
    data_b   = CPU_BUS.data == cmp_b[7:0];
    // Range modes: A is the low bound, B the high bound
    in_range = (CPU_BUS.addr >= cmp_a) && (CPU_BUS.addr <= cmp_b);
    event_only = (TRIGGER_MODE == dtc_pkg::TRG_EVENT_B) ||
                 (TRIGGER_MODE == dtc_pkg::TRG_A_THEN_EVENT_B);
    begin_mode = BEGIN_TRACE || event_only;
    case (TRIGGER_MODE)
      dtc_pkg::TRG_A_ONLY: begin
        trig = match_a;
      end
      dtc_pkg::TRG_A_OR_B: begin
        trig = match_a || match_b;
      end
      // A match is remembered for the rest of the run
      dtc_pkg::TRG_A_THEN_B: begin
        trig = seen_a && match_b;
      end
      dtc_pkg::TRG_EVENT_B: begin
        trig = match_b;
      end
      dtc_pkg::TRG_A_THEN_EVENT_B: begin
        trig = seen_a && match_b;
      end
      dtc_pkg::TRG_A_AND_B_DATA: begin
        trig = match_a && data_b;
      end
      dtc_pkg::TRG_A_NOT_B_DATA: begin
        trig = match_a && !data_b;
      end
      dtc_pkg::TRG_INSIDE: begin
        trig = CPU_BUS.valid && in_range;
      end
      dtc_pkg::TRG_OUTSIDE: begin
        trig = CPU_BUS.valid && !in_range;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
  end

  // ***********************************************************
  // Next-state logic
  // ***********************************************************
  logic        armed;
  logic        store;
  logic [15:0] store_word;
  logic        run_end;
  logic        low_read;
  logic        shift;
  logic [15:0] push_word;
  logic        push;
  dtc_pkg::dtc_ctrl_s wr_ctrl;

  always_comb begin
    armed       = ctrl.arm;
    store       = 1'b0;
    store_word  = dtc_pkg::RESET_WORD;
    run_end     = 1'b0;
    next_state  = state;
    next_seen_a = seen_a;
    next_flag_a = flag_a;
    next_flag_b = flag_b;
    next_count  = count;
    next_cmp_a  = cmp_a;
    next_cmp_b  = cmp_b;
    next_ctrl   = ctrl;
    next_rdata  = rdata;
    wr_ctrl     = dtc_pkg::dtc_ctrl_s'(REG_WDATA);

    // Capture while armed
    if (armed) begin
      if (match_a) begin
        next_seen_a = 1'b1;
        next_flag_a = 1'b1;
      end
      if (match_b) begin
        next_flag_b = 1'b1;
      end
      case (state)
        dtc_pkg::DTC_WAIT: begin
          // End trace: newest change-of-flow words, circular
          if (!begin_mode) begin
            if (COF_VALID) begin
              store      = 1'b1;
              store_word = COF_ADDR;
            end
            if (trig) begin
              run_end = 1'b1;
            end
          end else if (trig) begin
            next_state = dtc_pkg::DTC_FILL;
            if (event_only) begin
              store      = 1'b1;
              store_word = {8'h00, CPU_BUS.data};
            end
          end
        end
        dtc_pkg::DTC_FILL: begin
          if (event_only) begin
            store      = match_b;
            store_word = {8'h00, CPU_BUS.data};
          end else begin
            store      = COF_VALID;
            store_word = COF_ADDR;
          end
        end
        default: begin
          next_state = dtc_pkg::DTC_WAIT;
        end
      endcase
      // Count saturates at eight, never counts down
      if (store && count != dtc_pkg::FIFO_FULL_COUNT) begin
        next_count = count + 4'h1;
      end
      if (begin_mode && store &&
          count == dtc_pkg::FIFO_FULL_COUNT - 4'h1) begin
        run_end = 1'b1;
      end
      if (run_end) begin
        next_ctrl.arm = 1'b0;
        next_state    = dtc_pkg::DTC_IDLE;
      end
    end

    // Register writes
    // A control write overrides a run end in the same cycle
    if (REG_WR) begin
      if (REG_ADDR == dtc_pkg::ADDR_CMP_A_HIGH && !armed) begin
        next_cmp_a[15:8] = REG_WDATA;
      end else if (REG_ADDR == dtc_pkg::ADDR_CMP_A_LOW && !armed) begin
        next_cmp_a[7:0] = REG_WDATA;
      end else if (REG_ADDR == dtc_pkg::ADDR_CMP_B_HIGH && !armed) begin
        next_cmp_b[15:8] = REG_WDATA;
      end else if (REG_ADDR == dtc_pkg::ADDR_CMP_B_LOW && !armed) begin
        next_cmp_b[7:0] = REG_WDATA;
      end else if (REG_ADDR == dtc_pkg::ADDR_CONTROL) begin
        next_ctrl = wr_ctrl;
        next_ctrl.module_enable = wr_ctrl.module_enable &&
                                  (!MCU_SECURE || ctrl.module_enable);
        next_ctrl.arm = wr_ctrl.arm && next_ctrl.module_enable;
        if (next_ctrl.arm && !armed) begin
          next_state  = dtc_pkg::DTC_WAIT;
          next_count  = dtc_pkg::RESET_COUNT;
          next_seen_a = 1'b0;
          next_flag_a = 1'b0;
          next_flag_b = 1'b0;
        end else if (!next_ctrl.arm) begin
          next_state  = dtc_pkg::DTC_IDLE;
        end
      end
    end

    // FIFO movement
    // Reads while armed leave the words in place
    low_read  = REG_RD && (REG_ADDR == dtc_pkg::ADDR_FIFO_LOW);
    shift     = (low_read && !armed) || store;
    push      = store || (low_read && !armed);
    push_word = store ? store_word : LAST_OPCODE_ADDR;
    for (int i = 0; i < dtc_pkg::FIFO_DEPTH; i++) begin
      next_fifo[i] = fifo[i];
    end
    if (shift) begin
      for (int i = 0; i < dtc_pkg::FIFO_LAST; i++) begin
        next_fifo[i] = fifo[i + 1];
      end
    end
    if (push) begin
      next_fifo[dtc_pkg::FIFO_LAST] = push_word;
    end

    // Read data
    // Registered, held until the next read
    if (REG_RD) begin
      if (REG_ADDR == dtc_pkg::ADDR_CMP_A_HIGH) begin
        next_rdata = cmp_a[15:8];
      end else if (REG_ADDR == dtc_pkg::ADDR_CMP_A_LOW) begin
        next_rdata = cmp_a[7:0];
      end else if (REG_ADDR == dtc_pkg::ADDR_CMP_B_HIGH) begin
        next_rdata = cmp_b[15:8];
      end else if (REG_ADDR == dtc_pkg::ADDR_CMP_B_LOW) begin
        next_rdata = cmp_b[7:0];
      end else if (REG_ADDR == dtc_pkg::ADDR_FIFO_HIGH) begin
        next_rdata = event_only ? dtc_pkg::RESET_BYTE
                                : fifo[0][15:8];
      end else if (REG_ADDR == dtc_pkg::ADDR_FIFO_LOW) begin
        next_rdata = fifo[0][7:0];
      end else if (REG_ADDR == dtc_pkg::ADDR_CONTROL) begin
        next_rdata = ctrl;
      end else begin
        next_rdata = dtc_pkg::RESET_BYTE;
      end
    end

    // Break requests
    // One-cycle pulse after the run ends
    next_brk_force = run_end && ctrl.break_request_enable &&
                     !ctrl.trigger_type_select;
    next_brk_tag   = run_end && ctrl.break_request_enable &&
                     ctrl.trigger_type_select;

    // Forced reset from background commands only
    next_sys_reset = BDC_WR && (BDC_ADDR == dtc_pkg::ADDR_FORCED_RESET) &&
                     BDC_WDATA[dtc_pkg::BIT_FORCE_RESET];
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cmp_a     <= dtc_pkg::RESET_WORD;
      cmp_b     <= dtc_pkg::RESET_WORD;
      ctrl      <= dtc_pkg::RESET_CTRL;
      state     <= dtc_pkg::DTC_IDLE;
      for (int i = 0; i < dtc_pkg::FIFO_DEPTH; i++) begin
        fifo[i] <= dtc_pkg::RESET_WORD;
      end
      count     <= dtc_pkg::RESET_COUNT;
      seen_a    <= 1'b0;
      flag_a    <= 1'b0;
      flag_b    <= 1'b0;
      rdata     <= dtc_pkg::RESET_BYTE;
      brk_force <= 1'b0;
      brk_tag   <= 1'b0;
      sys_reset <= 1'b0;
    end else begin
      cmp_a     <= next_cmp_a;
      cmp_b     <= next_cmp_b;
      ctrl      <= next_ctrl;
      state     <= next_state;
      for (int i = 0; i < dtc_pkg::FIFO_DEPTH; i++) begin
        fifo[i] <= next_fifo[i];
      end
      count     <= next_count;
      seen_a    <= next_seen_a;
      flag_a    <= next_flag_a;
      flag_b    <= next_flag_b;
      rdata     <= next_rdata;
      brk_force <= next_brk_force;
      brk_tag   <= next_brk_tag;
      sys_reset <= next_sys_reset;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign REG_RDATA        = rdata;
  assign RUN_ACTIVE_FLAG  = ctrl.arm && ctrl.module_enable;
  assign FIFO_VALID_COUNT = count;
  assign MATCH_A_FLAG     = flag_a;
  assign MATCH_B_FLAG     = flag_b;
  assign BREAK_FORCE      = brk_force;
  assign BREAK_TAG        = brk_tag;
  assign SYSTEM_RESET_REQ = sys_reset;

endmodule : dtc_trace

// >>> verif/dtc_trace_checker.sv
// Assertion checker for the debug trace and compare block
module dtc_trace_checker (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  // Register and background ports
  input wire logic [3:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [3:0] BDC_ADDR,
  input wire logic       BDC_WR,
  input wire logic [7:0] BDC_WDATA,
  // Status and requests
  input wire logic       BEGIN_TRACE,
  input wire logic       RUN_ACTIVE_FLAG,
  input wire logic [3:0] FIFO_VALID_COUNT,
  input wire logic       BREAK_FORCE,
  input wire logic       BREAK_TAG,
  input wire logic       SYSTEM_RESET_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  AST_FR_PULSE: assert property (BDC_WR && BDC_ADDR == 4'h7 && BDC_WDATA[0]
    |=> SYSTEM_RESET_REQ) else $error("reset request missing");
  AST_FR_CAUSE: assert property (SYSTEM_RESET_REQ
    |-> $past(BDC_WR && BDC_ADDR == 4'h7 && BDC_WDATA[0]))
    else $error("reset request without background write");
  AST_FR_READ: assert property (REG_RD && REG_ADDR == 4'h7
    |=> REG_RDATA == 8'h00) else $error("forced reset read not zero");
  AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without read");
  AST_ARM_STOP: assert property (REG_WR && REG_ADDR == 4'h6
    && !(REG_WDATA[7] && REG_WDATA[6]) |=> !RUN_ACTIVE_FLAG)
    else $error("run not stopped by control write");
  AST_ARM_CAUSE: assert property ($rose(RUN_ACTIVE_FLAG)
    |-> $past(REG_WR && REG_ADDR == 4'h6 && REG_WDATA[6]))
    else $error("run started without arm write");
  AST_COUNT_CLR: assert property ($rose(RUN_ACTIVE_FLAG)
    |-> FIFO_VALID_COUNT == 4'h0) else $error("count not cleared");
  AST_COUNT_MAX: assert property (FIFO_VALID_COUNT <= 4'h8)
    else $error("count above eight");
  AST_COUNT_HOLD: assert property (REG_RD && REG_ADDR == 4'h5 && !REG_WR
    && !RUN_ACTIVE_FLAG |=> $stable(FIFO_VALID_COUNT))
    else $error("count changed on fifo read");
  AST_FULL_END: assert property (BEGIN_TRACE && FIFO_VALID_COUNT == 4'h8
    && $past(FIFO_VALID_COUNT) == 4'h7 |-> !RUN_ACTIVE_FLAG)
    else $error("begin trace not ended at full");
  AST_BRK_END: assert property (BREAK_FORCE || BREAK_TAG
    |-> $fell(RUN_ACTIVE_FLAG))
    else $error("break not one cycle after run end");
  AST_BRK_TYPE: assert property (!(BREAK_FORCE && BREAK_TAG))
    else $error("both break types at once");
endmodule : dtc_trace_checker

bind dtc_trace dtc_trace_checker i_dtc_trace_checker (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .BDC_ADDR(BDC_ADDR), .BDC_WR(BDC_WR), .BDC_WDATA(BDC_WDATA),
  .BEGIN_TRACE(BEGIN_TRACE), .RUN_ACTIVE_FLAG(RUN_ACTIVE_FLAG),
  .FIFO_VALID_COUNT(FIFO_VALID_COUNT), .BREAK_FORCE(BREAK_FORCE),
  .BREAK_TAG(BREAK_TAG), .SYSTEM_RESET_REQ(SYSTEM_RESET_REQ));

// >>> verif/dtc_cpu_model.sv
// Behavioural CPU: bus cycles, change-of-flow strobes, opcode fetch address
module dtc_cpu_model (
  // Clock
  input  wire logic        sys_clk,
  // Seen by the debug block
  output dtc_pkg::dtc_bus_s cpu_bus,
  output logic             cof_valid,
  output logic [15:0]      cof_addr,
  output logic [15:0]      opcode_addr
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cpu_bus = '0;
    cof_valid = 1'b0;
    cof_addr = 16'h0000;
    opcode_addr = 16'h0000;
  end

  // One bus cycle; idle address and data lines show the inverse afterwards, rd is kept
  task automatic bus(logic [15:0] a, logic rd, logic [7:0] d);
    @(negedge sys_clk);
    cpu_bus = {1'b1, rd, a, d};
    @(negedge sys_clk);
    cpu_bus = {1'b0, rd, ~a, ~d};
  endtask : bus

  task automatic cof(logic [15:0] a);
    @(negedge sys_clk);
    cof_valid = 1'b1;
    cof_addr = a;
    @(negedge sys_clk);
    cof_valid = 1'b0;
    cof_addr = ~a;
  endtask : cof

  task automatic fetch(logic [15:0] a);
    opcode_addr = a;
  endtask : fetch
endmodule : dtc_cpu_model

// >>> verif/tb_top.sv
// Self-checking bench for the debug trace and compare block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, reg_wr, reg_rd, bdc_wr, mcu_secure, begin_trace;
  logic [3:0] reg_addr, bdc_addr, trigger_mode, fifo_valid_count;
  logic [7:0] reg_wdata, reg_rdata, bdc_wdata, d;
  logic run_flag, match_a, match_b, brk_force, brk_tag, rst_req, cof_valid;
  logic rd_pend, armed, e_run;
  logic [15:0] cof_addr, opc_addr, cmp_a, cmp_b;
  dtc_pkg::dtc_bus_s cpu_bus;
  logic [15:0] fifo_m [8];
  logic [7:0] exp_q [$];
  string name_q [$];
  int fails, n_checks, n_force, n_tag, n_rst;

  dtc_trace i_dtc_trace (.SYS_CLK(sys_clk), .RESET(reset),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .BDC_ADDR(bdc_addr),
    .BDC_WR(bdc_wr), .BDC_WDATA(bdc_wdata), .CPU_BUS(cpu_bus),
    .COF_VALID(cof_valid), .COF_ADDR(cof_addr), .LAST_OPCODE_ADDR(opc_addr),
    .MCU_SECURE(mcu_secure), .TRIGGER_MODE(trigger_mode),
    .BEGIN_TRACE(begin_trace), .RUN_ACTIVE_FLAG(run_flag),
    .FIFO_VALID_COUNT(fifo_valid_count), .MATCH_A_FLAG(match_a),
    .MATCH_B_FLAG(match_b), .BREAK_FORCE(brk_force), .BREAK_TAG(brk_tag),
    .SYSTEM_RESET_REQ(rst_req));
  dtc_cpu_model u_cpu (.sys_clk(sys_clk), .cpu_bus(cpu_bus),
    .cof_valid(cof_valid), .cof_addr(cof_addr), .opcode_addr(opc_addr));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ***********************************************************
  // Checking and reporting
  // ***********************************************************
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) rd_pend <= reg_rd && !reset;
  always @(negedge sys_clk) begin
    if (rd_pend) chk(name_q.pop_front(), 16'(exp_q.pop_front()), 16'(reg_rdata));
    if (brk_force === 1'b1) n_force++;
    if (brk_tag === 1'b1) n_tag++;
    if (rst_req === 1'b1) n_rst++;
  end

  initial begin
    #2000000;
    fails++;
    print_verdict();
  end

  // ***********************************************************
  // Bus tasks and FIFO reference
  // ***********************************************************
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic bdc(logic [3:0] a, logic [7:0] v);
    @(negedge sys_clk);
    bdc_addr = a;
    bdc_wdata = v;
    bdc_wr = 1'b1;
    @(negedge sys_clk);
    bdc_wr = 1'b0;
  endtask : bdc

  task automatic rd(logic [3:0] a, logic [7:0] e, string nm);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask : rd

  function automatic void push(logic [15:0] w);
    for (int i = 0; i < 7; i++) fifo_m[i] = fifo_m[i+1];
    fifo_m[7] = w;
  endfunction : push

  // High byte first; low read shifts only when not armed
  task automatic rd_word();
    u_cpu.fetch(16'($urandom));
    rd(4'h4, trigger_mode == 4'h3 ? 8'h00 : fifo_m[0][15:8], "fifo_high");
    rd(4'h5, fifo_m[0][7:0], "fifo_low");
    if (!armed) push(opc_addr);
  endtask : rd_word

  task automatic wait_idle();
    int k;
    k = 0;
    while (run_flag !== 1'b0 && k < 50) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 50) begin
      fails++;
      print_verdict();
    end
    armed = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : wait_idle

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    {reset, reg_wr, reg_rd, bdc_wr, mcu_secure, begin_trace, armed} = 7'h40;
    {reg_addr, bdc_addr, trigger_mode, reg_wdata, bdc_wdata} = '0;
    {fails, n_checks, n_force, n_tag, n_rst} = '0;
    foreach (fifo_m[i]) fifo_m[i] = 16'h0000;
    void'($urandom(70));
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    for (int a = 0; a < 16; a++) if (a != 5) rd(4'(a), 8'h00, "reset_value");
    cmp_a = 16'($urandom);
    cmp_b = 16'($urandom);
    wr(4'h0, cmp_a[15:8]);
    wr(4'h1, cmp_a[7:0]);
    wr(4'h2, cmp_b[15:8]);
    wr(4'h3, cmp_b[7:0]);
    foreach (cmp_a[i]) if (i < 2) rd(4'(i), i ? cmp_a[7:0] : cmp_a[15:8], "cmp_a");
    rd(4'h3, cmp_b[7:0], "cmp_b_low");
    wr(4'h4, 8'hff);
    wr(4'h5, 8'hff);
    wr(4'h7, 8'h01);
    rd_word();
    rd(4'h7, 8'h00, "forced_reset");
    bdc(4'h7, 8'h01);
    bdc(4'h7, 8'h00);
    bdc(4'h3, 8'h01);
    chk("reset_req_count", 16'd1, 16'(n_rst));
    mcu_secure = 1'b1;
    wr(4'h6, 8'hc0);
    rd(4'h6, 8'h00, "control_secure");
    mcu_secure = 1'b0;
    wr(4'h6, 8'h2f);
    rd(4'h6, 8'h2f, "control");
    // End trace, A qualified on writes, force break
    wr(4'h6, 8'hd4);
    armed = 1'b1;
    chk("run_flag", 16'd1, 16'(run_flag));
    wr(4'h2, ~cmp_b[15:8]);
    rd(4'h2, cmp_b[15:8], "cmp_b_armed");
    repeat (3) begin
      cof_addr_q(16'($urandom));
    end
    rd_word();
    u_cpu.bus(cmp_a, 1'b1, 8'h00);
    @(negedge sys_clk);
    chk("run_after_read_cycle", 16'd1, 16'(run_flag));
    u_cpu.bus(cmp_a, 1'b0, 8'h00);
    wait_idle();
    chk("match_a", 16'd1, 16'(match_a));
    chk("force_breaks", 16'd1, 16'(n_force));
    repeat (8) rd_word();
    chk("count_end", 16'd3, 16'(fifo_valid_count));
    // Event-only begin trace, B qualified on reads, tag break
    trigger_mode = 4'h3;
    begin_trace = 1'b1;
    wr(4'h6, 8'hf3);
    armed = 1'b1;
    chk("count_start", 16'd0, 16'(fifo_valid_count));
    u_cpu.bus(cmp_b, 1'b0, 8'h5a);
    repeat (8) begin
      d = 8'($urandom);
      u_cpu.bus(cmp_b, 1'b1, d);
      push({8'h00, d});
    end
    wait_idle();
    chk("tag_breaks", 16'd1, 16'(n_tag));
    chk("count_full", 16'd8, 16'(fifo_valid_count));
    chk("match_b", 16'd1, 16'(match_b));
    repeat (8) rd_word();
    // Other trigger modes, end trace except event-only mode 4, break disabled
    begin_trace = 1'b0;
    for (int m = 1; m < 9; m++) if (m != 3) begin
      trigger_mode = 4'(m);
      wr(4'h6, 8'hc0);
      u_cpu.bus(cmp_a, 1'b0, cmp_b[7:0]);
      if (m == 2 || m == 4) u_cpu.bus(cmp_b, 1'b0, 8'h00);
      @(negedge sys_clk);
      e_run = m == 4 || m == 6 || (m == 7 && cmp_a > cmp_b) ||
              (m == 8 && cmp_a <= cmp_b);
      chk("mode_run", 16'(e_run), 16'(run_flag));
      wr(4'h6, 8'h00);
    end
    chk("no_break", 16'd2, 16'(n_force + n_tag));
    // Manual stop by arm or enable cleared
    trigger_mode = 4'h9;
    foreach (cmp_b[i]) if (i < 2) begin
      wr(4'h6, 8'hc0);
      wr(4'h6, i ? 8'h40 : 8'h80);
      chk("manual_stop", 16'd0, 16'(run_flag));
    end
    wr(4'h6, 8'hc0);
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    chk("run_after_reset", 16'd0, 16'(run_flag));
    rd(4'h1, 8'h00, "cmp_after_reset");
    print_verdict();
  end

  task automatic cof_addr_q(logic [15:0] a);
    u_cpu.cof(a);
    push(a);
  endtask : cof_addr_q
endmodule : tb_top
